// file: src/adv_port_reg.sv
// one port's ability advertisement word with its derived read-only bits
`timescale 1ns/100ps
`include "autoneg_defs.svh"
module adv_port_reg
  import autoneg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write access
  input wire logic we_i,
  input wire logic [1:0] sel_i,
  input wire logic [15:0] wdata_i,
  // configuration
  input wire logic an_en_i,
  input wire logic speed_100_i,
  // advertised word
  output autoneg_pkg::adv_word_t adv_o
);
  import autoneg_pkg::*;

  logic next_page;
  logic remote_fault;
  logic tx_fd;
  logic tx_hd;
  logic ten_hd;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      next_page <= 1'h0;  // [RULE_01]
      remote_fault <= 1'h0;  // [RULE_03]
      tx_fd <= 1'h0;  // [RULE_05]
      tx_hd <= `ADV_TX_RESET;  // [RULE_06]
    end else begin
      if (we_i && sel_i[1]) begin
        next_page <= wdata_i[`ADV_NP];  // [RULE_01]
        remote_fault <= wdata_i[`ADV_RF];  // [RULE_03]
        tx_fd <= wdata_i[`ADV_TXFD];  // [RULE_05]
      end
      if (we_i && sel_i[0]) begin
        tx_hd <= wdata_i[`ADV_TX];  // [RULE_06]
      end
    end
  end

  // 10BASE-T follows negotiation enable and forced speed; bit 5 is always set when enabled
  assign ten_hd = an_en_i || !speed_100_i;  // [RULE_07] [RULE_15]

  // reserved bits and T4 stay zero; selector is the fixed legal code
  always_comb begin
    adv_o = `ZERO16;  // [RULE_02] [RULE_04]
    adv_o[`ADV_NP] = next_page;
    adv_o[`ADV_RF] = remote_fault;
    adv_o[`ADV_TXFD] = tx_fd;
    adv_o[`ADV_TX] = tx_hd;
    adv_o[`ADV_10FD] = 1'h0;  // [RULE_07]
    adv_o[`ADV_10] = ten_hd;  // [RULE_07]
    adv_o[`ADV_SEL_HI:`ADV_SEL_LO] = `SEL_8023;  // [RULE_08]
  end
endmodule // adv_port_reg

// file: src/autoneg_defs.svh
// constants for the auto-negotiation advertisement and configuration registers
`ifndef AUTONEG_DEFS_SVH
`define AUTONEG_DEFS_SVH

// word index of each register; byte address is index times four
`define ADV_P1_IDX 8'hA6
`define ADV_P2_IDX 8'hA7
`define ADV_P3_IDX 8'hA8
`define ADV_P4_IDX 8'hA9
`define CFG_IDX 8'hAA
`define SPEED_IDX 8'hAB
`define STRAP_IDX 8'hAC
`define STATE_IDX 8'hAD

// advertisement field positions
`define ADV_NP 15
`define ADV_RF 13
`define ADV_T4 9
`define ADV_TXFD 8
`define ADV_TX 7
`define ADV_10FD 6
`define ADV_10 5
`define ADV_SEL_HI 4
`define ADV_SEL_LO 0

// writable advertisement bits: next page, remote fault, tx fd, tx
`define ADV_WMASK 16'hA180
`define ADV_RESET 16'h0000
`define ADV_TX_RESET 1'h1
`define SEL_8023 5'h01

// configuration fields
`define CFG_RESTART_HI 7
`define CFG_RESTART_LO 4
`define CFG_EN_HI 3
`define CFG_EN_LO 0
`define EN_RESET 4'hF

// port speed control: one bit per port, 1 = 100 Mb forced
`define SPEED_RESET 4'hF

`define NUM_PORTS 4
`define ZERO16 16'h0000
`define ZERO32 32'h00000000

`endif

// file: src/autoneg_pkg.sv
// types for the auto-negotiation register block
package autoneg_pkg;
  typedef logic [15:0] adv_word_t;
  typedef logic [3:0] port_mask_t;
endpackage

// file: src/autoneg_regs.sv
// auto-negotiation advertisement and configuration registers, wishbone slave
// Operation
// RULE_01: bit 15 advertises next page, resets 0
// RULE_02: bits 14, 12:10 reserved, zero
// RULE_03: bit 13 advertises remote fault, resets 0
// RULE_04: bit 9 T4 unsupported, always 0
// RULE_05: bit 8 advertises TX full duplex
// RULE_06: bit 7 advertises TX, resets 1
// RULE_07: bits 6,5 read-only; bit 5 derived
// RULE_08: selector fixed at 00001, never reserved
// RULE_09: restart bits act only when port enabled
// RULE_10: restart overrides strapped port configuration
// RULE_11: restart bits self-clear, reset zero
// RULE_12: enable bits read-write, reset one
// RULE_13: software writes speed and configuration registers
// RULE_14: disabled port uses forced speed
// RULE_15: enabled port advertises all abilities; code only forces bit 5, bits 8, 7 stay as written
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`include "autoneg_defs.svh"
module autoneg_regs
  import autoneg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // external strapped configuration pins
  input wire logic [3:0] strap_an_en_i,
  // port control toward negotiation engines
  output autoneg_pkg::port_mask_t restart_o,
  output autoneg_pkg::port_mask_t an_active_o,
  output autoneg_pkg::port_mask_t speed_100_o,
  output autoneg_pkg::adv_word_t adv_p1_o,
  output autoneg_pkg::adv_word_t adv_p2_o,
  output autoneg_pkg::adv_word_t adv_p3_o,
  output autoneg_pkg::adv_word_t adv_p4_o
);
  import autoneg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic [7:0] word_idx;
  logic access;
  logic wr_stb;
  logic hit_adv1;
  logic hit_adv2;
  logic hit_adv3;
  logic hit_adv4;
  logic hit_cfg;
  logic hit_speed;
  logic hit_strap;
  logic hit_state;
  logic mapped;

  assign word_idx = adr_i[9:2];
  assign access = cyc_i && stb_i && !ack_o && !err_o;
  assign hit_adv1 = word_idx == `ADV_P1_IDX;
  assign hit_adv2 = word_idx == `ADV_P2_IDX;
  assign hit_adv3 = word_idx == `ADV_P3_IDX;
  assign hit_adv4 = word_idx == `ADV_P4_IDX;
  assign hit_cfg = word_idx == `CFG_IDX;
  assign hit_speed = word_idx == `SPEED_IDX;
  assign hit_strap = word_idx == `STRAP_IDX;
  assign hit_state = word_idx == `STATE_IDX;
  assign mapped = hit_adv1 || hit_adv2 || hit_adv3 || hit_adv4 || hit_cfg
    || hit_speed || hit_strap || hit_state;
  assign wr_stb = access && we_i && mapped;

  ////////////////////////////////////////////////////////////////////////////
  // strap pins come from outside: two-stage synchroniser
  port_mask_t strap_meta;
  port_mask_t strap_sync;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_meta <= `EN_RESET;
      strap_sync <= `EN_RESET;
    end else begin
      strap_meta <= strap_an_en_i;
      strap_sync <= strap_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration, speed control and software override
  port_mask_t an_en;
  port_mask_t speed_100;
  port_mask_t sw_override;
  port_mask_t restart_wr;
  port_mask_t next_restart;
  port_mask_t next_override;
  port_mask_t eff_en;

  // a restart write takes effect only on enabled ports
  assign restart_wr = (wr_stb && hit_cfg && sel_i[0])
    ? (dat_i[`CFG_RESTART_HI:`CFG_RESTART_LO] & an_en) : 4'h0;  // [RULE_09]
  assign next_restart = restart_wr;  // [RULE_11]
  // once software restarts a port, the strap no longer governs it
  assign next_override = sw_override | restart_wr;  // [RULE_10]
  assign eff_en = (an_en & sw_override) | (an_en & strap_sync & ~sw_override);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      an_en <= `EN_RESET;  // [RULE_12]
      speed_100 <= `SPEED_RESET;
      sw_override <= 4'h0;
    end else begin
      if (wr_stb && hit_cfg && sel_i[0]) begin
        an_en <= dat_i[`CFG_EN_HI:`CFG_EN_LO];  // [RULE_12] [RULE_13]
      end
      if (wr_stb && hit_speed && sel_i[0]) begin
        speed_100 <= dat_i[`NUM_PORTS-1:0];  // [RULE_13]
      end
      sw_override <= next_override;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port advertisement words
  adv_word_t adv_w [`NUM_PORTS];
  logic [`NUM_PORTS-1:0] adv_hit;

  assign adv_hit = {hit_adv4, hit_adv3, hit_adv2, hit_adv1};

  genvar g;
  generate
    for (g = 0; g < `NUM_PORTS; g++) begin : g_port
      adv_port_reg u_adv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(wr_stb && adv_hit[g]),
        .sel_i(sel_i[1:0]),
        .wdata_i(dat_i[15:0]),
        .an_en_i(eff_en[g]),
        .speed_100_i(speed_100[g]),
        .adv_o(adv_w[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read mux; restart bits read as zero since they are write-only
  logic [31:0] rd_data;

  assign rd_data = hit_adv1 ? {`ZERO16, adv_w[0]}
    : hit_adv2 ? {`ZERO16, adv_w[1]}
    : hit_adv3 ? {`ZERO16, adv_w[2]}
    : hit_adv4 ? {`ZERO16, adv_w[3]}
    : hit_cfg ? {24'h000000, 4'h0, an_en}  // [RULE_11]
    : hit_speed ? {28'h0000000, speed_100}
    : hit_strap ? {28'h0000000, strap_sync}
    : hit_state ? {28'h0000000, eff_en}
    : `ZERO32;

  ////////////////////////////////////////////////////////////////////////////
  // bus answer and registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'h0;
      err_o <= 1'h0;
      dat_o <= `ZERO32;
      restart_o <= 4'h0;  // [RULE_11]
      an_active_o <= `EN_RESET;
      speed_100_o <= `SPEED_RESET;
      adv_p1_o <= `ZERO16;
      adv_p2_o <= `ZERO16;
      adv_p3_o <= `ZERO16;
      adv_p4_o <= `ZERO16;
    end else begin
      ack_o <= access && mapped;
      err_o <= access && !mapped;
      dat_o <= (access && mapped && !we_i) ? rd_data : `ZERO32;
      restart_o <= next_restart;  // [RULE_09] [RULE_11]
      an_active_o <= eff_en;
      // a disabled port runs at the forced speed  [RULE_14]
      speed_100_o <= speed_100;
      adv_p1_o <= adv_w[0];
      adv_p2_o <= adv_w[1];
      adv_p3_o <= adv_w[2];
      adv_p4_o <= adv_w[3];
    end
  end
endmodule // autoneg_regs

// file: tb/autoneg_props.sv
// assertion checker for the auto-negotiation register block
`timescale 1ns/100ps
module autoneg_props
  import autoneg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire logic err_o,
  // port control
  input autoneg_pkg::port_mask_t restart_o,
  input autoneg_pkg::port_mask_t an_active_o,
  input autoneg_pkg::port_mask_t speed_100_o,
  input autoneg_pkg::adv_word_t adv_p1_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////
  property p_defaults; $fell(rst_i) |=> adv_p1_o == 16'h00A1; endproperty
  a_defaults: assert property (p_defaults) else $error("bad default");
  property p_sel; !$past(rst_i) |-> adv_p1_o[4:0] == 5'h01; endproperty
  a_sel: assert property (p_sel) else $error("bad selector");
  property p_rsv; adv_p1_o[14] == 1'b0 && adv_p1_o[12:10] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_t4; adv_p1_o[9] == 1'b0; endproperty
  a_t4: assert property (p_t4) else $error("four-pair bit set");
  property p_b5;
    !$past(rst_i) && $stable(an_active_o) && $stable(speed_100_o)
      |-> adv_p1_o[5] == (an_active_o[0] | !speed_100_o[0]) && !adv_p1_o[6];
  endproperty
  a_b5: assert property (p_b5) else $error("derived bit wrong");
  property p_clear; restart_o != 4'h0 |=> restart_o == 4'h0; endproperty
  a_clear: assert property (p_clear) else $error("restart held");
  property p_rs_ack; restart_o != 4'h0 |-> ack_o && $past(cyc_i && stb_i && we_i); endproperty
  a_rs_ack: assert property (p_rs_ack) else $error("restart without write");
  property p_spd; $fell(rst_i) |-> speed_100_o == 4'hF && an_active_o == 4'hF; endproperty
  a_spd: assert property (p_spd) else $error("bad control default");
  property p_ans; ack_o || err_o |=> !ack_o && !err_o; endproperty
  a_ans: assert property (p_ans) else $error("answer held");
endmodule // autoneg_props

bind autoneg_regs autoneg_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o, .err_o,
  .restart_o, .an_active_o, .speed_100_o, .adv_p1_o);

// file: tb/testbench.sv
// self-checking bench for the auto-negotiation register block
`timescale 1ns/100ps
module testbench;
  import autoneg_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, eb;
  logic [9:0] adr_i;
  logic [3:0] sel_i, strap_an_en_i, rs;
  logic [31:0] dat_i, dat_o, q;
  logic [15:0] d;
  port_mask_t restart_o, an_active_o, speed_100_o;
  adv_word_t adv_o [4];
  int num_errors, compares, seed, i;
  autoneg_regs DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .err_o, .strap_an_en_i, .restart_o, .an_active_o, .speed_100_o,
    .adv_p1_o(adv_o[0]), .adv_p2_o(adv_o[1]), .adv_p3_o(adv_o[2]), .adv_p4_o(adv_o[3]));
  ////////////////////////////////////////////////
  task automatic conclude;
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // one classic cycle; captures data, error and restart pulses with the answer
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {a, 2'h0};
    dat_i <= v;
    // answer is sampled at the rising edge, before the design updates it
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack_o || err_o) && n < 20);
    q = dat_o;
    eb = err_o;
    rs = restart_o;
    if (!(ack_o || err_o)) begin
      num_errors++;
      conclude();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [31:0] adv_exp(logic [15:0] v, logic b5);
    return {16'h0, v & 16'hA180} | {26'h0, b5, 5'h01};
  endfunction
  ////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    seed = 18534;
    num_errors = 0;
    compares = 0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 10'h0;
    sel_i = 4'hF;
    dat_i = 32'h0;
    strap_an_en_i = 4'hF;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 4; i++) begin
      wb(1'b0, 8'hA6 + 8'(i), 32'h0);
      chk(q, 32'h00A1);
      chk(adv_o[i], 32'h00A1);
    end
    wb(1'b0, 8'hAA, 32'h0);
    chk(q, 32'h0F);
    $display("defaults test done");
    for (i = 0; i < 12; i++) begin
      d = (i < 2) ? {16{i[0]}} : 16'($random(seed));
      wb(1'b1, 8'hA6 + 8'(i % 4), {16'hFFFF, d});
      wb(1'b0, 8'hA6 + 8'(i % 4), 32'h0);
      chk(q, adv_exp(d, 1'b1));
      chk(adv_o[i % 4], adv_exp(d, 1'b1));
    end
    $display("advertisement test done");
    wb(1'b1, 8'hAA, 32'hE);
    chk(an_active_o, 4'hE);
    wb(1'b0, 8'hA6, 32'h0);
    chk(q & 32'h7F, 32'h01);
    wb(1'b1, 8'hAB, 32'hE);
    wb(1'b0, 8'hA6, 32'h0);
    chk(q & 32'h7F, 32'h21);
    chk(speed_100_o, 4'hE);
    wb(1'b1, 8'hAA, 32'h1E);
    chk(rs, 4'h0);
    strap_an_en_i <= 4'hB;
    repeat (4) @(posedge clk_i);
    chk(an_active_o, 4'hA);
    wb(1'b1, 8'hAA, 32'hFE);
    chk(rs, 4'hE);
    chk(an_active_o, 4'hE);
    wb(1'b0, 8'hAA, 32'h0);
    chk(q, 32'h0E);
    $display("configuration test done");
    wb(1'b1, 8'h00, 32'hFFFF);
    chk(eb, 1'b1);
    chk(q, 32'h0);
    $display("unmapped test done");
    conclude();
  end
endmodule // testbench
